// ### tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// Register indices; byte address is four times the index
`define TCC_IDX_CH0_CS      8'h45
`define TCC_IDX_CH0_HI      8'h46
`define TCC_IDX_CH0_LO      8'h47
`define TCC_IDX_CH1_CS      8'h48
`define TCC_IDX_CH1_HI      8'h49
`define TCC_IDX_CH1_LO      8'h4a

// Field positions in a channel control/status byte
`define TCC_BIT_FLAG        7
`define TCC_BIT_IRQ_EN      6
`define TCC_BIT_BUF         5
`define TCC_BIT_MODE        4
`define TCC_BIT_ELS_HI      3
`define TCC_BIT_ELS_LO      2
`define TCC_BIT_TOV         1
`define TCC_BIT_MAX         0

// Reset value of each control/status byte
`define TCC_CS_RESET        8'h00

// Edge/level field codes
`define TCC_ELS_OFF         2'h0
`define TCC_ELS_TOGGLE      2'h1
`define TCC_ELS_LOW         2'h2
`define TCC_ELS_HIGH        2'h3

// Register kinds inside a channel
`define TCC_KIND_CS         2'h0
`define TCC_KIND_HI         2'h1
`define TCC_KIND_LO         2'h2

// Bus response codes
`define TCC_RESP_OKAY       2'h0
`define TCC_RESP_SLVERR     2'h2

`endif

// ### tcc_pkg.sv
package tcc_pkg;

  // Software-writable control bits of one channel
  typedef struct packed {
    logic       irq_en;
    logic       buf_sel;
    logic       mode_sel;
    logic [1:0] els;
    logic       tov;
    logic       max;
  } tcc_ctrl_t;

  // Result of an address decode
  typedef struct packed {
    logic       hit;
    logic       ch;
    logic [1:0] kind;
  } tcc_dec_t;

  // Drive of one channel pin
  typedef struct packed {
    logic out;
    logic oe;
  } tcc_pin_t;

  // Write response state
  typedef enum logic [1:0] {
    TCC_B_IDLE = 2'b01,
    TCC_B_RESP = 2'b10
  } tcc_bst_t;

endpackage

// ### tcc_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

// Overview of operation
// - Capture edge sets flag, latches counter
// - Compare equality sets channel event flag
// - Flag clears by read then zero write
// - Reset clears flag; writing one ignored
// - Interrupt enable gates flag onto request
// - Buffered bit disables channel one; its value pair feeds channel zero
// - Mode bit picks capture or compare
// - Field zero: mode bit sets initial level
// - Field zero disconnects pin from channel
// - Edge field picks rising, falling, both
// - Edge field picks toggle, low, high
// - Buffered bit forces buffered compare mode
// - Toggle on wrap in compare mode
// - Wrap toggle beats simultaneous compare match
// - Full duty force applies next period
// - Sixteen-bit value register pair per channel
// - High read blocks captures until low
// - High write blocks compares until low
// - Counter halt blocks all captures
module tcc_capture_compare #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 12
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Shared counter, same clock
  input  wire logic [CNT_W-1:0]     counter_value,
  input  wire logic                 counter_tick,
  input  wire logic                 counter_wrap,
  input  wire logic                 counter_halt,
  // Channel pins and requests
  input  wire logic [1:0]           channel_pin,
  output var tcc_pkg::tcc_pin_t [1:0] pin_drive,
  output logic [1:0]                channel_irq
);
  // Byte-wide value registers only serve a 16-bit counter; index needs bits 9:2
  if (CNT_W != 16 || ADDR_W < 10) begin : g_bad_param
    $error("tcc_capture_compare: CNT_W must be 16 and ADDR_W at least 10");
  end

  // Map a word index to channel and register kind
  function automatic tcc_pkg::tcc_dec_t decode(input logic [7:0] idx);
    tcc_pkg::tcc_dec_t d;
    d = '0;
    case (idx)
      `TCC_IDX_CH0_CS: d = '{hit: 1'b1, ch: 1'b0, kind: `TCC_KIND_CS};
      `TCC_IDX_CH0_HI: d = '{hit: 1'b1, ch: 1'b0, kind: `TCC_KIND_HI};
      `TCC_IDX_CH0_LO: d = '{hit: 1'b1, ch: 1'b0, kind: `TCC_KIND_LO};
      `TCC_IDX_CH1_CS: d = '{hit: 1'b1, ch: 1'b1, kind: `TCC_KIND_CS};
      `TCC_IDX_CH1_HI: d = '{hit: 1'b1, ch: 1'b1, kind: `TCC_KIND_HI};
      `TCC_IDX_CH1_LO: d = '{hit: 1'b1, ch: 1'b1, kind: `TCC_KIND_LO};
      default:         d = '0;
    endcase
    return d;
  endfunction

  // Active edge per edge/level code
  function automatic logic edge_hit(input logic [1:0] els, input logic rise, input logic fall);
    case (els)
      `TCC_ELS_TOGGLE: return rise;
      `TCC_ELS_LOW:    return fall;
      `TCC_ELS_HIGH:   return rise | fall;
      default:         return 1'b0;
    endcase
  endfunction

  // Output level after a compare action
  function automatic logic cmp_action(input logic [1:0] els, input logic cur);
    case (els)
      `TCC_ELS_TOGGLE: return ~cur;
      `TCC_ELS_LOW:    return 1'b0;
      `TCC_ELS_HIGH:   return 1'b1;
      default:         return cur;
    endcase
  endfunction

  tcc_pkg::tcc_ctrl_t ctrl [2];
  tcc_pkg::tcc_bst_t  bst;
  logic [7:0]         val_hi [2];
  logic [7:0]         val_lo [2];
  logic [1:0]         flag;
  logic [1:0]         arm;
  logic [1:0]         rlock;
  logic [1:0]         wlock;
  logic [1:0]         out_state;
  logic [1:0]         pin_oe_q;
  logic [1:0]         max_eff;
  logic               buf_pick;
  logic [1:0]         sync1;
  logic [1:0]         sync2;
  logic [1:0]         sync3;
  logic               aw_held;
  logic               w_held;
  logic [7:0]         aw_idx;
  logic [7:0]         w_byte;
  logic               w_lane0;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic               rvalid_q;
  logic [1:0]         bresp_q;
  logic               buf0;
  logic               ch1_on;
  logic [1:0]         els_on;
  logic [1:0]         cmp_mode;
  logic [1:0]         cap_mode;
  logic [1:0]         mode00;
  logic [15:0]        cmp_val [2];
  logic [1:0]         cmp_lock;
  logic [1:0]         cap_ev;
  logic [1:0]         match;
  logic [1:0]         event_hit;
  logic               wr_go;
  logic               wr_en;
  logic               rd_go;
  tcc_pkg::tcc_dec_t  wdec;
  tcc_pkg::tcc_dec_t  rdec;

  // Channel mode decode
  always_comb begin
    buf0        = ctrl[0].buf_sel;
    ch1_on      = ~buf0;
    els_on[0]   = ctrl[0].els != `TCC_ELS_OFF;
    els_on[1]   = ctrl[1].els != `TCC_ELS_OFF;
    cmp_mode[0] = els_on[0] & (ctrl[0].mode_sel | buf0);
    cmp_mode[1] = ch1_on & els_on[1] & ctrl[1].mode_sel;
    cap_mode[0] = els_on[0] & ~ctrl[0].mode_sel & ~buf0;
    cap_mode[1] = ch1_on & els_on[1] & ~ctrl[1].mode_sel;
    mode00[0]   = ~ctrl[0].mode_sel & ~buf0;
    mode00[1]   = ~ctrl[1].mode_sel & ~buf0;
    // Buffered pair: channel 0 compares against whichever half is live
    cmp_val[0]  = (buf0 & buf_pick) ? {val_hi[1], val_lo[1]} : {val_hi[0], val_lo[0]};
    cmp_lock[0] = (buf0 & buf_pick) ? wlock[1] : wlock[0];
    cmp_val[1]  = {val_hi[1], val_lo[1]};
    cmp_lock[1] = wlock[1];
    for (int c = 0; c < 2; c++) begin
      cap_ev[c] = cap_mode[c] & ~counter_halt & ~rlock[c]
                  & edge_hit(ctrl[c].els, sync2[c] & ~sync3[c], ~sync2[c] & sync3[c]);
      match[c]  = cmp_mode[c] & counter_tick & ~cmp_lock[c]
                  & (counter_value == cmp_val[c]);
      event_hit[c] = cap_ev[c] | match[c];
    end
  end

  // Bus handshakes; readies drop while frozen so nothing is lost
  assign s_axi_awready = ce & ~aw_held & (bst == tcc_pkg::TCC_B_IDLE);
  assign s_axi_wready  = ce & ~w_held & (bst == tcc_pkg::TCC_B_IDLE);
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid  = bst == tcc_pkg::TCC_B_RESP;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_go = ce & aw_held & w_held & (bst == tcc_pkg::TCC_B_IDLE);
  assign wdec  = decode(aw_idx);
  assign wr_en = wr_go & wdec.hit & w_lane0;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign rdec  = decode(s_axi_araddr[9:2]);

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 8'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[9:2];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bst     <= tcc_pkg::TCC_B_IDLE;
      bresp_q <= `TCC_RESP_OKAY;
    end else if (ce) begin
      case (bst)
        tcc_pkg::TCC_B_IDLE: begin
          if (wr_go) begin
            bst     <= tcc_pkg::TCC_B_RESP;
            bresp_q <= wdec.hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
          end
        end
        tcc_pkg::TCC_B_RESP: begin
          if (s_axi_bready) begin
            bst <= tcc_pkg::TCC_B_IDLE;
          end
        end
        default: bst <= tcc_pkg::TCC_B_IDLE;
      endcase
    end
  end

  // Read data; reserved and unmapped bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `TCC_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rdec.hit ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        rdata_q  <= 32'h0000_0000;
        if (rdec.hit) begin
          case (rdec.kind)
            `TCC_KIND_CS: begin
              rdata_q[`TCC_BIT_FLAG]   <= flag[rdec.ch];
              rdata_q[`TCC_BIT_IRQ_EN] <= ctrl[rdec.ch].irq_en;
              rdata_q[`TCC_BIT_BUF]    <= ctrl[rdec.ch].buf_sel;
              rdata_q[`TCC_BIT_MODE]   <= ctrl[rdec.ch].mode_sel;
              rdata_q[`TCC_BIT_ELS_HI] <= ctrl[rdec.ch].els[1];
              rdata_q[`TCC_BIT_ELS_LO] <= ctrl[rdec.ch].els[0];
              rdata_q[`TCC_BIT_TOV]    <= ctrl[rdec.ch].tov;
              rdata_q[`TCC_BIT_MAX]    <= ctrl[rdec.ch].max;
            end
            `TCC_KIND_HI: rdata_q[7:0] <= val_hi[rdec.ch];
            `TCC_KIND_LO: rdata_q[7:0] <= val_lo[rdec.ch];
            default:      rdata_q[7:0] <= 8'h00;
          endcase
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Control fields; channel 1 ignores writes while paired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl[0] <= tcc_pkg::tcc_ctrl_t'(7'(`TCC_CS_RESET));
      ctrl[1] <= tcc_pkg::tcc_ctrl_t'(7'(`TCC_CS_RESET));
    end else if (ce && wr_en && wdec.kind == `TCC_KIND_CS && (!wdec.ch || ch1_on)) begin
      ctrl[wdec.ch].irq_en   <= w_byte[`TCC_BIT_IRQ_EN];
      ctrl[wdec.ch].buf_sel  <= wdec.ch ? 1'b0 : w_byte[`TCC_BIT_BUF];
      ctrl[wdec.ch].mode_sel <= w_byte[`TCC_BIT_MODE];
      ctrl[wdec.ch].els      <= {w_byte[`TCC_BIT_ELS_HI], w_byte[`TCC_BIT_ELS_LO]};
      ctrl[wdec.ch].tov      <= w_byte[`TCC_BIT_TOV];
      ctrl[wdec.ch].max      <= w_byte[`TCC_BIT_MAX];
    end
  end

  // Event flags with two-step clear; a new event always wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 2'h0;
      arm  <= 2'h0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (event_hit[c]) begin
          flag[c] <= 1'b1;
          arm[c]  <= 1'b0;
        end else if (wr_en && wdec.kind == `TCC_KIND_CS && wdec.ch == c[0] && (c == 0 || ch1_on)
                     && !w_byte[`TCC_BIT_FLAG] && arm[c]) begin
          flag[c] <= 1'b0;
          arm[c]  <= 1'b0;
        end else if (rd_go && rdec.hit && rdec.kind == `TCC_KIND_CS && rdec.ch == c[0] && flag[c]) begin
          arm[c] <= 1'b1;
        end
      end
    end
  end

  assign channel_irq = flag & {ctrl[1].irq_en, ctrl[0].irq_en};

  // Value registers: undefined at reset, capture beats a software write
  always_ff @(posedge aclk) begin
    if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (cap_ev[c]) begin
          {val_hi[c], val_lo[c]} <= counter_value;
        end else if (wr_en && wdec.ch == c[0] && wdec.kind == `TCC_KIND_HI) begin
          val_hi[c] <= w_byte;
        end else if (wr_en && wdec.ch == c[0] && wdec.kind == `TCC_KIND_LO) begin
          val_lo[c] <= w_byte;
        end
      end
    end
  end

  // Half-access locks for capture reads and compare writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rlock <= 2'h0;
      wlock <= 2'h0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (rd_go && rdec.hit && rdec.ch == c[0] && rdec.kind == `TCC_KIND_HI && mode00[c]) begin
          rlock[c] <= 1'b1;
        end else if (rd_go && rdec.hit && rdec.ch == c[0] && rdec.kind == `TCC_KIND_LO) begin
          rlock[c] <= 1'b0;
        end
        if (wr_en && wdec.ch == c[0] && wdec.kind == `TCC_KIND_HI && !mode00[c]) begin
          wlock[c] <= 1'b1;
        end else if (wr_en && wdec.ch == c[0] && wdec.kind == `TCC_KIND_LO) begin
          wlock[c] <= 1'b0;
        end
      end
    end
  end

  // Full-duty latch moves only at period edges; buffer half select flips there and clears whenever unbuffered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_pick <= 1'b0;
      max_eff  <= 2'h0;
    end else if (ce) begin
      if (!buf0) begin
        buf_pick <= 1'b0;
      end else if (counter_wrap) begin
        buf_pick <= ~buf_pick;
      end
      if (counter_wrap) begin
        max_eff <= {ctrl[1].max, ctrl[0].max};
      end
    end
  end

  // Pin synchroniser; third stage only feeds the edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      sync3 <= 2'h0;
    end else if (ce) begin
      sync1 <= channel_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Output level per channel; wrap toggle takes precedence over a match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_state <= 2'h0;
      pin_oe_q  <= 2'h0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        pin_oe_q[c] <= cmp_mode[c];
        if (!els_on[c]) begin
          out_state[c] <= ~ctrl[c].mode_sel;
        end else if (cmp_mode[c]) begin
          if ((counter_wrap ? ctrl[c].max : max_eff[c]) && !ctrl[c].tov) begin // Wrap cycle opens the new period
            out_state[c] <= 1'b1;
          end else if (ctrl[c].tov && counter_wrap) begin
            out_state[c] <= ~out_state[c];
          end else if (match[c]) begin
            out_state[c] <= cmp_action(ctrl[c].els, out_state[c]);
          end
        end
      end
    end
  end

  // Pin drive straight from flops
  assign pin_drive = {out_state[1], pin_oe_q[1], out_state[0], pin_oe_q[0]};

endmodule
`default_nettype wire

// ### tcc_capture_compare_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module tcc_capture_compare_asserts #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 12
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  ce,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic [ADDR_W-1:0]     s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire tcc_pkg::tcc_pin_t [1:0] pin_drive,
  input wire logic [1:0]            channel_irq
);
  default clocking dcb @(posedge aclk);
  endclocking

  // Reset must silence answers, requests and pin drive whatever ce does
  chk_reset_quiet: assert property (
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && channel_irq == 2'h0
      && !pin_drive[0].oe && !pin_drive[1].oe)
    else $error("reset left an output active");
  chk_read_turn: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_unmapped: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !(s_axi_araddr[9:2] inside {[8'h45:8'h4a]})
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Registers are bytes; upper lanes stay quiet
  chk_rdata_byte: assert property (disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  chk_write_turn: assert property (disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rdata_hold: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  chk_ce_stall: assert property (disable iff (!aresetn)
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus taken while clock enable low");
  chk_ar_refused: assert property (disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken early");
endmodule
`default_nettype wire

// ### tcc_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

// External source on the channel pins
module tcc_pin_src (
  input  wire logic                   aclk,
  input  wire logic [1:0]             level_req,
  input  wire tcc_pkg::tcc_pin_t [1:0] pin_drive,
  output logic [1:0]                  channel_pin
);
  logic [1:0] ext_level;

  // Moves only on an edge then holds, so capture never sees glitches
  always_ff @(posedge aclk) begin
    ext_level <= level_req;
  end

  // Channel drive wins while enabled, else the external level
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      channel_pin[c] = pin_drive[c].oe ? pin_drive[c].out : ext_level[c];
    end
  end
endmodule
`default_nettype wire

// ### timer_channel_capture_compare_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module timer_channel_capture_compare_tb;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic                    ce = 1'b1;
  logic [11:0]             s_axi_awaddr = 12'h0;
  logic                    s_axi_awvalid = 1'b0;
  logic                    s_axi_awready;
  logic [31:0]             s_axi_wdata = 32'h0;
  logic [3:0]              s_axi_wstrb = 4'h0;
  logic                    s_axi_wvalid = 1'b0;
  logic                    s_axi_wready;
  logic [1:0]              s_axi_bresp;
  logic                    s_axi_bvalid;
  logic                    s_axi_bready = 1'b0;
  logic [11:0]             s_axi_araddr = 12'h0;
  logic                    s_axi_arvalid = 1'b0;
  logic                    s_axi_arready;
  logic [31:0]             s_axi_rdata;
  logic [1:0]              s_axi_rresp;
  logic                    s_axi_rvalid;
  logic                    s_axi_rready = 1'b0;
  logic [15:0]             counter_value = 16'h0;
  logic                    counter_tick;
  logic                    counter_wrap;
  logic                    counter_halt = 1'b0;
  logic [1:0]              channel_pin;
  tcc_pkg::tcc_pin_t [1:0] pin_drive;
  logic [1:0]              channel_irq;
  logic                    run = 1'b0;
  logic [1:0]              level_req = 2'h0;
  logic                    exp_out = 1'b1;
  logic                    f;
  logic [15:0]             cap_val;
  logic [15:0]             cap_old;
  logic [1:0]              els;
  logic [1:0]              act[3] = '{2'h1, 2'h3, 2'h2};
  logic [33:0]             rq[$];
  logic [1:0]              bq[$];
  int                      seed = 32'h3b6b;
  int                      cycles = 0;
  int                      num_errors = 0;
  int                      comparisons = 0;

  always #2.5 aclk = ~aclk;

  // 64-count timebase, ticking every cycle while running
  always @(posedge aclk) begin
    if (run) begin
      counter_value <= (counter_value == 16'h3f) ? 16'h0 : counter_value + 16'h1;
    end
  end
  assign counter_tick = run;
  assign counter_wrap = run && counter_value == 16'h0;

  tcc_capture_compare tcc_capture_compare_inst (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .counter_value, .counter_tick, .counter_wrap, .counter_halt, .channel_pin,
    .pin_drive, .channel_irq);
  tcc_pin_src tcc_pin_src_inst (.aclk, .level_req, .pin_drive, .channel_pin);

  task automatic complete_run();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] expv);
    comparisons++;
    if (seen !== expv) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, expv, seen);
    end
  endtask

  // Answers are matched to the oldest outstanding note
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
    end
  end

  // Extra edge at the end keeps the next request off this time step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `TCC_RESP_OKAY);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(er);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Ready comes a cycle late so the held answer is exercised
  task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er = `TCC_RESP_OKAY);
    rq.push_back({er, 24'h0, ed});
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic at(input logic [15:0] v);
    do @(posedge aclk); while (counter_value !== v);
  endtask

  // Frozen random count, then a pin step on channel 1
  task automatic pin_step(input logic lvl);
    cap_val = 16'($random(seed));
    counter_value <= cap_val;
    level_req[1] <= lvl;
    repeat (6) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    rd(`TCC_IDX_CH0_CS, `TCC_CS_RESET);
    rd(`TCC_IDX_CH1_CS, `TCC_CS_RESET);
    rd(8'h50, 8'h00, `TCC_RESP_SLVERR);
    wr(8'h44, 8'h55, `TCC_RESP_SLVERR);
    // Set-on-match at 0x10, set up with the counter stopped
    wr(`TCC_IDX_CH0_HI, 8'h00);
    wr(`TCC_IDX_CH0_LO, 8'h10);
    wr(`TCC_IDX_CH0_CS, 8'h5c);
    run <= 1'b1;
    at(16'h14);
    check("irq0", 34'(channel_irq[0]), 34'h1);
    check("pin0", 34'({pin_drive[0].oe, pin_drive[0].out}), 34'h3);
    wr(`TCC_IDX_CH0_CS, 8'hdc);
    rd(`TCC_IDX_CH0_CS, 8'hdc);
    wr(`TCC_IDX_CH0_CS, 8'h5c);
    rd(`TCC_IDX_CH0_CS, 8'h5c);
    // A match between arming read and zero write keeps the flag
    at(16'h14);
    rd(`TCC_IDX_CH0_CS, 8'hdc);
    at(16'h14);
    wr(`TCC_IDX_CH0_CS, 8'h5c);
    rd(`TCC_IDX_CH0_CS, 8'hdc);
    wr(`TCC_IDX_CH0_CS, 8'h9c);
    check("irq_masked", 34'(channel_irq[0]), 34'h0);
    for (int i = 0; i < 3; i++) begin
      els = act[i];
      wr(`TCC_IDX_CH0_CS, {4'h1, els, 2'b00});
      exp_out = (els == `TCC_ELS_TOGGLE) ? !exp_out : els[0];
      at(16'h14);
      check("pin_action", 34'(pin_drive[0].out), 34'(exp_out));
    end
    // Match at zero meets the wrap; the wrap toggle must beat set
    wr(`TCC_IDX_CH0_LO, 8'h00);
    wr(`TCC_IDX_CH0_CS, 8'h1e);
    repeat (2) begin
      at(16'h14);
      exp_out = !exp_out;
      check("pin_wrap", 34'(pin_drive[0].out), 34'(exp_out));
    end
    wr(`TCC_IDX_CH0_CS, 8'h19);
    at(16'h14);
    check("pin_full", 34'(pin_drive[0].out), 34'h1);
    wr(`TCC_IDX_CH0_CS, 8'h18);
    at(16'h14);
    check("pin_full_off", 34'(pin_drive[0].out), 34'h0);
    // High-byte write holds off the match at zero until the low byte
    wr(`TCC_IDX_CH0_CS, 8'h1c);
    wr(`TCC_IDX_CH0_HI, 8'h00);
    at(16'h14);
    check("pin_locked", 34'(pin_drive[0].out), 34'h0);
    wr(`TCC_IDX_CH0_LO, 8'h00);
    at(16'h14);
    check("pin_unlocked", 34'(pin_drive[0].out), 34'h1);
    run <= 1'b0;
    wr(`TCC_IDX_CH1_CS, 8'h1c);
    check("pin1_oe", 34'(pin_drive[1].oe), 34'h1);
    wr(`TCC_IDX_CH0_CS, 8'h3c);
    rd(`TCC_IDX_CH0_CS, 8'hbc);
    check("pin1_free", 34'(pin_drive[1].oe), 34'h0);
    wr(`TCC_IDX_CH0_CS, 8'h00);
    check("pin0_free", 34'({pin_drive[0].oe, pin_drive[0].out}), 34'h1);
    wr(`TCC_IDX_CH0_CS, 8'h10);
    check("pin0_init_low", 34'(pin_drive[0].out), 34'h0);
    wr(`TCC_IDX_CH1_CS, 8'h00);
    // Each edge code against a rise then a fall
    for (int e = 1; e < 4; e++) begin
      els = 2'(e);
      wr(`TCC_IDX_CH1_CS, {4'h4, els, 2'b00});
      for (int l = 1; l >= 0; l--) begin
        pin_step(l[0]);
        f = (l == 1) ? els[0] : els[1];
        check("irq1", 34'(channel_irq[1]), 34'(f));
        rd(`TCC_IDX_CH1_CS, {f, 3'b100, els, 2'b00});
        wr(`TCC_IDX_CH1_CS, {4'h4, els, 2'b00});
        if (f) begin
          rd(`TCC_IDX_CH1_HI, cap_val[15:8]);
          rd(`TCC_IDX_CH1_LO, cap_val[7:0]);
        end
      end
    end
    counter_halt <= 1'b1;
    pin_step(1'b1);
    check("irq_halt", 34'(channel_irq[1]), 34'h0);
    counter_halt <= 1'b0;
    // High-byte read freezes the captured pair until the low byte
    pin_step(1'b0);
    cap_old = cap_val;
    rd(`TCC_IDX_CH1_HI, cap_old[15:8]);
    pin_step(1'b1);
    rd(`TCC_IDX_CH1_LO, cap_old[7:0]);
    complete_run();
  end
endmodule

bind tcc_capture_compare tcc_capture_compare_asserts #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) tcc_chk (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .pin_drive, .channel_irq);
`default_nettype wire
